// ---- include/deser_cfg_pkg.sv ----
// Package: register map, field layout and reset values of the config bank
package deser_cfg_pkg;

    // ************************************************************
    // Register offsets and bus address values
    // ************************************************************
    localparam logic [7:0] OFS_CONFIG_ONE   = 8'h00; // Config register
    localparam logic [7:0] OFS_SLAVE_ADDR   = 8'h01; // Address select register
    localparam logic [7:0] OFS_FEATURES_ONE = 8'h02; // Output features register
    localparam logic [6:0] ADDR_RESET       = 7'h70; // Reset value of address field
    localparam logic [6:0] ADDR_A           = 7'h71; // Valid address one
    localparam logic [6:0] ADDR_B           = 7'h72; // Valid address two
    localparam logic [6:0] ADDR_C           = 7'h73; // Valid address three
    localparam logic [6:0] ADDR_D           = 7'h76; // Valid address four

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int BIT_LOW_FREQ  = 7; // Range select
    localparam int BIT_MAP_SEL   = 6; // Fourth pair mapping
    localparam int BIT_MODE_HI   = 3; // Link mode high bit
    localparam int BIT_MODE_LO   = 2; // Link mode low bit
    localparam int BIT_SLEEP     = 1; // Sleep request
    localparam int BIT_REG_CTRL  = 0; // Register control
    localparam int BIT_ADDR_SRC  = 7; // Address source
    localparam int BIT_DRIVE_ON  = 7; // Output drive on
    localparam int BIT_IDLE_SEL  = 6; // Output idle state
    localparam int BIT_SWING     = 3; // Output swing
    localparam int BIT_OSC_HI    = 2; // Oscillator select high bit

    // ************************************************************
    // Reset values and oscillator codes
    // ************************************************************
    localparam logic [7:0] RST_CONFIG_ONE   = 8'h00; // Pins govern after reset
    localparam logic [7:0] RST_SLAVE_ADDR   = 8'h70; // Strap source, default field
    localparam logic [7:0] RST_FEATURES_ONE = 8'h00; // All off
    localparam logic [2:0] OSC_OFF          = 3'h0;  // Fallback clock off
    localparam logic [2:0] OSC_RSVD         = 3'h1;  // Reserved code

    // Link mode encodings
    typedef enum logic [1:0] {
        MODE_NORMAL_NOFILT = 2'h0,
        MODE_NORMAL_FILT   = 2'h1,
        MODE_COMPAT_A      = 2'h2,
        MODE_COMPAT_B      = 2'h3
    } link_mode_e;

    // Effective settings handed to the datapath
    typedef struct packed {
        logic       low_freq_range_sel;
        logic       output_bit_map_sel;
        link_mode_e link_mode;
        logic       sleep;
        logic       output_drive_on;
        logic       output_idle_state_sel;
        logic       output_swing_sel;
        logic [2:0] fallback_osc_freq_sel;
    } cfg_s;

    // Pin-side settings, used while registers do not govern
    typedef struct packed {
        logic       low_freq_range_sel;
        logic       output_bit_map_sel;
        link_mode_e link_mode;
        logic       output_drive_on;
        logic       output_idle_state_sel;
        logic       output_swing_sel;
        logic [2:0] fallback_osc_freq_sel;
    } pin_cfg_s;

endpackage

// ---- verilog/deser_config_register_bank.sv ----
// Configuration register bank of the deserializer, written by the serial control engine
//
// Behaviour
// - Reg0 bit7 picks low or high range
// - Reg0 bits3:2 choose link mode
// - Reg0 bit1 sleeps, registers kept
// - Reg0 bit0 picks pins or registers
// - Reg1 bit7 picks strap or register address
// - Address field resets 0x70; four valid
// - Reg2 bits7,6 drive-on and idle select
// - Reg2 bit3 selects output swing
// - Reset leaves pins governing; write 01
// - Lost stream gives oscillator clock out
// - Registers reached through serial slave
`timescale 1ns/1ps

module deser_config_register_bank (
    input  wire logic                      ref_clk,
    input  wire logic                      reset,
    input  wire logic                      reg_wr_en,
    input  wire logic                      reg_rd_en,
    input  wire logic [7:0]                reg_addr,
    input  wire logic [7:0]                reg_wdata,
    output logic      [7:0]                reg_rdata,
    output logic                           reg_ack,
    input  wire logic [6:0]                bus_address_strap,
    input  wire deser_cfg_pkg::pin_cfg_s   pin_cfg,
    input  wire logic                      stream_lost,
    output deser_cfg_pkg::cfg_s            cfg_out,
    output logic      [6:0]                bus_address_value,
    output logic                           bus_address_valid,
    output logic                           lvds_clock_from_osc
);

    // ************************************************************
    // Register state
    // ************************************************************
    logic [7:0] config_one_q;   // Config register
    logic [7:0] config_one_d;   // Its next value
    logic [7:0] slave_addr_q;   // Address select register
    logic [7:0] slave_addr_d;   // Its next value
    logic [7:0] features_one_q; // Features register
    logic [7:0] features_one_d; // Its next value
    logic [7:0] rdata_q;        // Read data, held from flops
    logic [7:0] rdata_d;        // Its next value
    logic       ack_q;          // Access answered
    logic       ack_d;          // Its next value

    // Next values: writes land on the addressed register only
    always_comb begin
        config_one_d   = config_one_q;
        slave_addr_d   = slave_addr_q;
        features_one_d = features_one_q;
        rdata_d        = rdata_q;
        ack_d          = 1'b0;
        if (reg_wr_en) begin
            ack_d = 1'b1;
            case (reg_addr)
                deser_cfg_pkg::OFS_CONFIG_ONE: begin
                    config_one_d = reg_wdata;
                end
                deser_cfg_pkg::OFS_SLAVE_ADDR: begin
                    slave_addr_d = reg_wdata;
                end
                deser_cfg_pkg::OFS_FEATURES_ONE: begin
                    features_one_d = reg_wdata;
                end
                // Unmapped offsets: acknowledged, data dropped
                default: begin
                    ack_d = 1'b1;
                end
            endcase
        end else if (reg_rd_en) begin
            ack_d = 1'b1;
            case (reg_addr)
                deser_cfg_pkg::OFS_CONFIG_ONE: begin
                    rdata_d = config_one_q;
                end
                deser_cfg_pkg::OFS_SLAVE_ADDR: begin
                    rdata_d = slave_addr_q;
                end
                deser_cfg_pkg::OFS_FEATURES_ONE: begin
                    rdata_d = features_one_q;
                end
                // Unmapped reads return zero
                default: begin
                    rdata_d = 8'h00;
                end
            endcase
        end
    end

    // Registers; reset models power-down, so sleep does not clear them
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            config_one_q   <= deser_cfg_pkg::RST_CONFIG_ONE;
            slave_addr_q   <= deser_cfg_pkg::RST_SLAVE_ADDR;
            features_one_q <= deser_cfg_pkg::RST_FEATURES_ONE;
            rdata_q        <= 8'h00;
            ack_q          <= 1'b0;
        end else begin
            config_one_q   <= config_one_d;
            slave_addr_q   <= slave_addr_d;
            features_one_q <= features_one_d;
            rdata_q        <= rdata_d;
            ack_q          <= ack_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_ack   = ack_q;

    // ************************************************************
    // Effective configuration
    // ************************************************************
    logic                     reg_ctrl;   // Registers govern
    deser_cfg_pkg::cfg_s      cfg_d;      // Effective settings
    deser_cfg_pkg::cfg_s      cfg_q;      // Registered for the datapath
    logic [6:0]               addr_d;     // Chosen bus address
    logic [6:0]               addr_q;     // Registered address
    logic                     addr_ok_d;  // Address is a valid one
    logic                     addr_ok_q;  // Registered validity
    logic                     osc_clk_d;  // Oscillator clock out
    logic                     osc_clk_q;  // Registered

    assign reg_ctrl = config_one_q[deser_cfg_pkg::BIT_REG_CTRL];

    // Mux pins or registers into the effective settings
    always_comb begin
        if (reg_ctrl) begin
            cfg_d.low_freq_range_sel    = config_one_q[deser_cfg_pkg::BIT_LOW_FREQ];
            cfg_d.output_bit_map_sel    = config_one_q[deser_cfg_pkg::BIT_MAP_SEL];
            cfg_d.link_mode             = deser_cfg_pkg::link_mode_e'(
                config_one_q[deser_cfg_pkg::BIT_MODE_HI:deser_cfg_pkg::BIT_MODE_LO]);
            cfg_d.output_drive_on       = features_one_q[deser_cfg_pkg::BIT_DRIVE_ON];
            cfg_d.output_idle_state_sel = features_one_q[deser_cfg_pkg::BIT_IDLE_SEL];
            cfg_d.output_swing_sel      = features_one_q[deser_cfg_pkg::BIT_SWING];
            cfg_d.fallback_osc_freq_sel = features_one_q[deser_cfg_pkg::BIT_OSC_HI:0];
        end else begin
            // Pins govern while register control is clear
            cfg_d.low_freq_range_sel    = pin_cfg.low_freq_range_sel;
            cfg_d.output_bit_map_sel    = pin_cfg.output_bit_map_sel;
            cfg_d.link_mode             = pin_cfg.link_mode;
            cfg_d.output_drive_on       = pin_cfg.output_drive_on;
            cfg_d.output_idle_state_sel = pin_cfg.output_idle_state_sel;
            cfg_d.output_swing_sel      = pin_cfg.output_swing_sel;
            cfg_d.fallback_osc_freq_sel = pin_cfg.fallback_osc_freq_sel;
        end
        cfg_d.sleep = config_one_q[deser_cfg_pkg::BIT_SLEEP];
    end

    // ************************************************************
    // Bus address selection and fallback clock
    // ************************************************************

    // Address source, independent of register control
    always_comb begin
        if (slave_addr_q[deser_cfg_pkg::BIT_ADDR_SRC]) begin
            addr_d = slave_addr_q[6:0];
        end else begin
            // Strap pin decides while the source bit is clear
            addr_d = bus_address_strap;
        end
        case (addr_d)
            deser_cfg_pkg::ADDR_A,
            deser_cfg_pkg::ADDR_B,
            deser_cfg_pkg::ADDR_C,
            deser_cfg_pkg::ADDR_D: begin
                addr_ok_d = 1'b1;
            end
            default: begin
                addr_ok_d = 1'b0;
            end
        endcase
    end

    // Fallback clock when stream lost; off and reserved codes idle
    // Reserved code stays quiet: its frequency is not defined
    always_comb begin
        osc_clk_d = stream_lost
                  && (cfg_d.fallback_osc_freq_sel != deser_cfg_pkg::OSC_OFF)
                  && (cfg_d.fallback_osc_freq_sel != deser_cfg_pkg::OSC_RSVD);
    end

    // ************************************************************
    // Output registers
    // ************************************************************

    // Output flops; one cycle of latency keeps outputs glitch free
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cfg_q     <= '0;
            addr_q    <= deser_cfg_pkg::ADDR_RESET;
            addr_ok_q <= 1'b0;
            osc_clk_q <= 1'b0;
        end else begin
            cfg_q     <= cfg_d;
            addr_q    <= addr_d;
            addr_ok_q <= addr_ok_d;
            osc_clk_q <= osc_clk_d;
        end
    end

    assign cfg_out             = cfg_q;
    assign bus_address_value   = addr_q;
    assign bus_address_valid   = addr_ok_q;
    assign lvds_clock_from_osc = osc_clk_q;

endmodule

// ---- test/deser_cfg_assertions.sv ----
// Checker of the config bank port timing
`timescale 1ns/1ps
module deser_cfg_assertions (
    input wire logic                ref_clk,
    input wire logic                reset,
    input wire logic                reg_wr_en,
    input wire logic                reg_rd_en,
    input wire logic [7:0]          reg_addr,
    input wire logic [7:0]          reg_wdata,
    input wire logic [7:0]          reg_rdata,
    input wire logic                reg_ack,
    input wire deser_cfg_pkg::cfg_s cfg_out,
    input wire logic [6:0]          bus_address_value,
    input wire logic                bus_address_valid,
    input wire logic                lvds_clock_from_osc
);
    // ************************************************************
    // Port relations
    // ************************************************************
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    a_ack_follows: assert property ((reg_wr_en | reg_rd_en) |=> reg_ack)
        else $error("ack missing");
    a_ack_idle: assert property (!(reg_wr_en | reg_rd_en) |=> !reg_ack)
        else $error("ack without request");
    a_unmapped_zero: assert property (reg_rd_en && !reg_wr_en && reg_addr > 8'h02
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    a_rdata_holds: assert property (!reg_rd_en || reg_wr_en |=> $stable(reg_rdata))
        else $error("read data moved");
    a_sleep_bit: assert property (reg_wr_en && reg_addr == 8'h00 |-> ##2
        cfg_out.sleep == $past(reg_wdata[1], 2)) else $error("sleep wrong");
    a_mode_regs: assert property (reg_wr_en && reg_addr == 8'h00 && reg_wdata[0]
        |-> ##2 cfg_out.link_mode == $past(reg_wdata[3:2], 2)) else $error("mode wrong");
    a_addr_reg: assert property (reg_wr_en && reg_addr == 8'h01 && reg_wdata[7]
        |-> ##2 bus_address_value == $past(reg_wdata[6:0], 2)) else $error("address wrong");
    a_addr_valid: assert property (bus_address_valid ==
        (bus_address_value inside {7'h71, 7'h72, 7'h73, 7'h76})) else $error("valid wrong");
    a_osc_gated: assert property (lvds_clock_from_osc |->
        cfg_out.fallback_osc_freq_sel > 3'h1) else $error("osc clock while off");
endmodule

bind deser_config_register_bank deser_cfg_assertions i_chk (.ref_clk, .reset, .reg_wr_en,
    .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .reg_ack, .cfg_out, .bus_address_value,
    .bus_address_valid, .lvds_clock_from_osc);

// ---- test/cfg_host_model.sv ----
// Host side model issuing byte writes and reads to the bank
`timescale 1ns/1ps
module cfg_host_model (
    input  wire logic       ref_clk,
    input  wire logic       reg_ack,
    input  wire logic [7:0] reg_rdata,
    output logic            reg_wr_en,
    output logic            reg_rd_en,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata
);
    // ************************************************************
    // Byte transfers
    // ************************************************************
    initial begin
        {reg_wr_en, reg_rd_en, reg_addr, reg_wdata} = '0;
    end
    task automatic xfer(input logic wr, input logic [7:0] a, d, output logic [7:0] q,
                        output logic ok);
        @(negedge ref_clk);
        {reg_wr_en, reg_rd_en, reg_addr, reg_wdata} = {wr, !wr, a, d};
        @(negedge ref_clk);
        ok = (reg_ack === 1'b1);
        q = reg_rdata;
        // Released lines show the inverse so stale values never pass
        {reg_wr_en, reg_rd_en, reg_addr, reg_wdata} = {2'h0, ~a, ~d};
    endtask
endmodule

// ---- test/deser_config_register_bank_bench.sv ----
// Self-checking bench of the config register bank
`timescale 1ns/1ps
module deser_config_register_bank_bench;
    logic        ref_clk, reset, reg_wr_en, reg_rd_en, reg_ack, stream_lost, ok;
    logic        bus_address_valid, lvds_clock_from_osc;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, q, d;
    logic [6:0]  bus_address_strap, bus_address_value;
    logic [9:0]  pin_cfg;
    logic [10:0] cfg_out, e;
    logic [31:0] w;
    logic [7:0]  r [3];
    int          errors = 0, comparisons = 0, seed = 32'hFF01B114;

    deser_config_register_bank i_dut (.ref_clk, .reset, .reg_wr_en, .reg_rd_en, .reg_addr,
        .reg_wdata, .reg_rdata, .reg_ack, .bus_address_strap, .pin_cfg, .stream_lost,
        .cfg_out, .bus_address_value, .bus_address_valid, .lvds_clock_from_osc);
    cfg_host_model i_host (.ref_clk, .reg_ack, .reg_rdata, .reg_wr_en, .reg_rd_en,
        .reg_addr, .reg_wdata);

    // ************************************************************
    // Helpers
    // ************************************************************
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // Settings from registers when bit0 is set, else pins
    function automatic logic [10:0] exp_cfg();
        logic [9:0] s;
        s = r[0][0] ? {r[0][7:6], r[0][3:2], r[2][7:6], r[2][3:0]} : pin_cfg;
        return {s[9:6], r[0][1], s[5:0]};
    endfunction
    task automatic chk(input logic [31:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, v);
        i_host.xfer(1'b1, a, v, q, ok);
        chk(ok, 1);
        if (a < 8'h03) r[a] = v;
    endtask
    task automatic check_all();
        logic [6:0] a;
        for (int i = 0; i < 4; i++) begin
            i_host.xfer(1'b0, i[7:0], 8'h00, q, ok);
            chk({ok, q}, {1'b1, (i < 3) ? r[i] : 8'h00});
        end
        e = exp_cfg();
        a = r[1][7] ? r[1][6:0] : bus_address_strap;
        chk(cfg_out, e);
        chk(bus_address_value, a);
        chk(bus_address_valid, a inside {7'h71, 7'h72, 7'h73, 7'h76});
        chk(lvds_clock_from_osc, stream_lost && e[2:0] > 3'h1);
    endtask
    task automatic do_reset();
        @(negedge ref_clk);
        reset = 1'b1;
        repeat (2) @(negedge ref_clk);
        reset = 1'b0;
        r = '{8'h00, 8'h70, 8'h00};
    endtask
    task automatic wrap_up();
        if (errors == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        repeat (100000) @(posedge ref_clk);
        errors++;
        wrap_up();
    end
    initial begin
        reset = 1'b1;
        {pin_cfg, bus_address_strap, stream_lost} = '0;
        do_reset();
        check_all();
        for (int n = 0; n < 60; n++) begin
            w = $random(seed);
            {pin_cfg, bus_address_strap, stream_lost} = w[17:0];
            d = w[25:18];
            // valid bus address in half the draws: 71, 72, 73 or 76
            if (w[28]) d[6:0] = 7'h70 + {4'h0, w[30:29]} + ((w[30:29] == 2'h3) ? 7'h3 : 7'h1);
            wr_reg({6'h00, w[27:26]}, d);
            check_all();
        end
        for (int k = 0; k < 8; k++) begin
            stream_lost = 1'b1;
            wr_reg(8'h02, {5'h00, k[2:0]});
            wr_reg(8'h00, {4'h0, k[1:0], 2'h1});
            check_all();
        end
        // Reset mid-run restores defaults
        do_reset();
        check_all();
        wrap_up();
    end
endmodule
